// File: design/bu_brake_ctrl.sv
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module bu_brake_ctrl #(
  parameter logic [bu_pkg::CNT_W-1:0]  DEB_CYC   = bu_pkg::CNT_W'(bu_pkg::DEB_CYC),
  parameter logic [bu_pkg::CNT_W-1:0]  FLASH_CYC = bu_pkg::CNT_W'(bu_pkg::FLASH_CYC),
  parameter logic [bu_pkg::LOCK_W-1:0] LOCK_CYC  = bu_pkg::LOCK_W'(bu_pkg::LOCK_CYC),
  parameter logic [bu_pkg::INT_W-1:0]  ON_LIMIT  = bu_pkg::INT_W'(bu_pkg::ON_LIMIT)
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [bu_pkg::WB_AW-1:0] wb_adr_i,
  input  wire logic [bu_pkg::WB_DW-1:0] wb_dat_i,
  input  wire logic [bu_pkg::WB_SW-1:0] wb_sel_i,
  output logic      [bu_pkg::WB_DW-1:0] wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic                     inhibit_ack_input_i,
  input  wire logic                     manual_discharge_input_i,
  input  wire logic                     discharge_indicator_high_i,
  input  wire logic                     overcurrent_i,
  input  wire logic                     heatsink_overtemp_i,
  output logic                          resistor_switch_o,
  output logic                          overload_prewarn_output_o,
  output logic                          ready_fault_output_o,
  output logic                          ready_led_green_o,
  output logic                          ready_led_red_o,
  output logic                          discharge_indicator_o
);
  import bu_pkg::*;

  // Filtered inputs
  bu_lvl_if inh_if ();
  bu_lvl_if man_if ();

  bu_in_filt #(
    .DEB  (DEB_CYC),
    .INIT (1'b1)
  ) u_inh_filt (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .raw_i   (inhibit_ack_input_i),
    .lvl_o   (inh_if.src)
  );

  bu_in_filt #(
    .DEB  (DEB_CYC),
    .INIT (1'b0)
  ) u_man_filt (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .raw_i   (manual_discharge_input_i),
    .lvl_o   (man_if.src)
  );

  // On-time integral
  logic             res_on_r;
  logic             res_on_nxt;
  logic [INT_W-1:0] ont_cnt;
  logic             ont_warn;
  logic             ont_trip;

  bu_on_integ #(
    .LIMIT (ON_LIMIT)
  ) u_integ (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .on_i    (res_on_r),
    .cnt_o   (ont_cnt),
    .warn_o  (ont_warn),
    .trip_o  (ont_trip)
  );

  // Bus slave
  logic              ack_r;
  logic              ack_nxt;
  logic [WB_DW-1:0]  rdat_r;
  logic [WB_DW-1:0]  rdat_nxt;
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [WB_DW-1:0]  stat_word;

  // Faults and lockout
  logic              oc_r;
  logic              oc_nxt;
  logic              ot_r;
  logic              ot_nxt;
  logic              ovl_r;
  logic              ovl_nxt;
  logic [LOCK_W-1:0] lock_r;
  logic [LOCK_W-1:0] lock_nxt;
  logic              lock_act;
  logic              ack_ev;
  logic              flt_any;
  logic              flt_any_nxt;

  // Drive and mode
  logic              inh;
  logic              req;
  bu_state_t         st_r;
  bu_state_t         st_nxt;

  // Flash timer
  logic [CNT_W-1:0]  fcnt_r;
  logic [CNT_W-1:0]  fcnt_nxt;
  logic              fph_r;
  logic              fph_nxt;

  // Registered outputs
  logic              warn_n_r;
  logic              warn_n_nxt;
  logic              rdy_r;
  logic              rdy_nxt;
  logic              grn_r;
  logic              grn_nxt;
  logic              red_r;
  logic              red_nxt;
  logic              dled_r;
  logic              dled_nxt;

  assign stat_word = {{(WB_DW - STAT_MAN - 1){1'b0}}, man_if.lvl, inh_if.lvl, res_on_r,
                      ont_warn, lock_act, ovl_r, ot_r, oc_r};

  always_comb begin
    ack_nxt  = wb_cyc_i & wb_stb_i & ~ack_r;
    rdat_nxt = rdat_r;
    ctrl_nxt = ctrl_r;
    if (ack_nxt && !wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL: rdat_nxt = {{(WB_DW - CTRL_W){1'b0}}, ctrl_r};
        ADR_STAT: rdat_nxt = stat_word;
        ADR_ONT:  rdat_nxt = WB_DW'(ont_cnt >> ONT_SH);
        default:  rdat_nxt = '0;
      endcase
    end
    if (ack_r && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL) begin
      ctrl_nxt = wb_dat_i[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r  <= 1'b0;
      rdat_r <= '0;
      ctrl_r <= CTRL_RST;
    end else begin
      ack_r  <= ack_nxt;
      rdat_r <= rdat_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // Fault capture, acknowledge and lockout
  assign lock_act = lock_r != '0;
  assign ack_ev   = inh_if.fall & ~lock_act;
  assign flt_any  = oc_r | ot_r | ovl_r;

  always_comb begin
    oc_nxt   = (oc_r & ~ack_ev) | overcurrent_i;
    ot_nxt   = (ot_r & ~ack_ev) | heatsink_overtemp_i;
    ovl_nxt  = (ovl_r & ~ack_ev) | ont_trip;
    lock_nxt = lock_r;
    if (ont_trip) begin
      lock_nxt = LOCK_CYC;
    end else if (lock_act) begin
      lock_nxt = lock_r - 1'b1;
    end
    flt_any_nxt = oc_nxt | ot_nxt | ovl_nxt;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oc_r   <= 1'b0;
      ot_r   <= 1'b0;
      ovl_r  <= 1'b0;
      lock_r <= '0;
    end else begin
      oc_r   <= oc_nxt;
      ot_r   <= ot_nxt;
      ovl_r  <= ovl_nxt;
      lock_r <= lock_nxt;
    end
  end

  // Resistor drive and operating mode
  assign inh = inh_if.lvl | ctrl_r[CTRL_INH];
  assign req = man_if.lvl | (ctrl_r[CTRL_CHOP] & discharge_indicator_high_i);

  always_comb begin
    res_on_nxt = req & ~inh & ~flt_any_nxt;
    case (1'b1)
      flt_any_nxt: st_nxt = BU_ST_FAULT;
      inh:         st_nxt = BU_ST_INHIBIT;
      default:     st_nxt = BU_ST_READY;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_on_r <= 1'b0;
      st_r     <= BU_ST_INHIBIT;
    end else begin
      res_on_r <= res_on_nxt;
      st_r     <= st_nxt;
    end
  end

  assign resistor_switch_o = res_on_r;

  // Free-running flash phase
  always_comb begin
    fcnt_nxt = fcnt_r + 1'b1;
    fph_nxt  = fph_r;
    if (fcnt_r >= FLASH_CYC - 1'b1) begin
      fcnt_nxt = '0;
      fph_nxt  = ~fph_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fcnt_r <= '0;
      fph_r  <= 1'b0;
    end else begin
      fcnt_r <= fcnt_nxt;
      fph_r  <= fph_nxt;
    end
  end

  // Terminal outputs and LEDs
  always_comb begin
    warn_n_nxt = ~ont_warn;
    rdy_nxt    = ~flt_any;
    case (st_r)
      BU_ST_READY: begin
        grn_nxt = 1'b1;
        red_nxt = 1'b0;
      end
      BU_ST_INHIBIT, BU_ST_FAULT: begin
        grn_nxt = 1'b0;
        red_nxt = 1'b1;
      end
      default: begin
        grn_nxt = 1'b0;
        red_nxt = 1'b1;
      end
    endcase
    dled_nxt = res_on_r & fph_r;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      warn_n_r <= 1'b1;
      rdy_r    <= 1'b1;
      grn_r    <= 1'b0;
      red_r    <= 1'b1;
      dled_r   <= 1'b0;
    end else begin
      warn_n_r <= warn_n_nxt;
      rdy_r    <= rdy_nxt;
      grn_r    <= grn_nxt;
      red_r    <= red_nxt;
      dled_r   <= dled_nxt;
    end
  end

  assign overload_prewarn_output_o = warn_n_r;
  assign ready_fault_output_o      = rdy_r;
  assign ready_led_green_o         = grn_r;
  assign ready_led_red_o           = red_r;
  assign discharge_indicator_o     = dled_r;

  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  inhibit_off_a: assert property (inh |=> !resistor_switch_o)
    else $error("Resistor on while inhibited");

  manual_on_a: assert property (man_if.lvl && !inh && !flt_any_nxt |=> resistor_switch_o)
    else $error("Manual discharge did not switch resistor on");

  manual_idle_a: assert property (!man_if.lvl && !(ctrl_r[CTRL_CHOP] && discharge_indicator_high_i)
    |=> !resistor_switch_o)
    else $error("Resistor on without request");

  ack_clear_a: assert property (ack_ev && !overcurrent_i && !heatsink_overtemp_i && !ont_trip
    |=> !flt_any ##1 ready_fault_output_o)
    else $error("Acknowledge did not clear faults");

  lock_hold_a: assert property (ovl_r && lock_act |=> ovl_r)
    else $error("Overload fault cleared during lockout");

  lock_load_a: assert property (ont_trip |=> lock_r == LOCK_CYC && ovl_r)
    else $error("Lockout not started on overload trip");

  prewarn_out_a: assert property (ont_warn |=> !overload_prewarn_output_o)
    else $error("Pre-warning not driven low");

  fault_ready_a: assert property ($rose(overcurrent_i) |=> oc_r
    ##1 !ready_fault_output_o && !resistor_switch_o)
    else $error("Fault did not drop ready");

  led_ready_a: assert property (st_r == BU_ST_READY |=> ready_led_green_o && !ready_led_red_o)
    else $error("Green LED wrong while ready");

  led_red_a: assert property (st_r != BU_ST_READY |=> ready_led_red_o && !ready_led_green_o)
    else $error("Red LED wrong while inhibited or faulted");

  dled_dark_a: assert property (!res_on_r |=> !discharge_indicator_o)
    else $error("Discharge LED lit with resistor off");
endmodule : bu_brake_ctrl

// File: design/bu_in_filt.sv
`timescale 1ns/1ps
module bu_in_filt #(
  parameter logic [bu_pkg::CNT_W-1:0] DEB  = bu_pkg::CNT_W'(bu_pkg::DEB_CYC),
  parameter logic                     INIT = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic raw_i,
  bu_lvl_if.src     lvl_o
);
  import bu_pkg::*;

  logic             sync1_r;
  logic             sync2_r;
  logic             stab_r;
  logic             stab_nxt;
  logic             fall_r;
  logic             fall_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // Level accepted only after a full stable window
  always_comb begin
    cnt_nxt  = '0;
    stab_nxt = stab_r;
    fall_nxt = 1'b0;
    if (sync2_r != stab_r) begin
      if (cnt_r >= DEB - 1'b1) begin
        stab_nxt = sync2_r;
        fall_nxt = stab_r & ~sync2_r;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= INIT;
      sync2_r <= INIT;
      stab_r  <= INIT;
      fall_r  <= 1'b0;
      cnt_r   <= '0;
    end else begin
      sync1_r <= raw_i;
      sync2_r <= sync1_r;
      stab_r  <= stab_nxt;
      fall_r  <= fall_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign lvl_o.lvl  = stab_r;
  assign lvl_o.fall = fall_r;

  deb_window_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(stab_r) |-> $past(cnt_r) == DEB - 1'b1)
    else $error("Filtered level changed before window");

  deb_fall_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fall_r |-> $fell(stab_r))
    else $error("Fall pulse without filtered falling edge");
endmodule : bu_in_filt

// File: design/bu_lvl_if.sv
`timescale 1ns/1ps
interface bu_lvl_if;
  logic lvl;
  logic fall;
  modport src (output lvl, output fall);
  modport dst (input lvl, input fall);
endinterface : bu_lvl_if

// File: design/bu_on_integ.sv
`timescale 1ns/1ps
module bu_on_integ #(
  parameter logic [bu_pkg::INT_W-1:0] LIMIT = bu_pkg::INT_W'(bu_pkg::ON_LIMIT)
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     on_i,
  output logic      [bu_pkg::INT_W-1:0] cnt_o,
  output logic                          warn_o,
  output logic                          trip_o
);
  import bu_pkg::*;

  localparam logic [INT_W-1:0] WGT  = INT_W'(ON_WEIGHT);
  localparam logic [INT_W-1:0] WARN = INT_W'((LIMIT / PCT_FULL) * PREWARN_PCT);

  logic [INT_W-1:0] cnt_r;
  logic [INT_W-1:0] cnt_nxt;

  // Heats while on, cools while off
  always_comb begin
    cnt_nxt = cnt_r;
    if (on_i) begin
      cnt_nxt = (cnt_r >= LIMIT - WGT) ? LIMIT : cnt_r + WGT;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign cnt_o  = cnt_r;
  assign warn_o = cnt_r >= WARN;
  assign trip_o = cnt_r >= LIMIT;

  integ_rise_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    on_i && cnt_r < LIMIT - WGT |=> cnt_r == $past(cnt_r) + WGT)
    else $error("On-time integral did not rise");

  integ_decay_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !on_i && cnt_r != '0 |=> cnt_r == $past(cnt_r) - 1'b1)
    else $error("On-time integral did not decay");
endmodule : bu_on_integ

// File: design/bu_pkg.sv
package bu_pkg;
  // Clock and timing
  localparam longint unsigned CLK_HZ      = 100_000_000;
  localparam longint unsigned DEB_US      = 1000;
  localparam longint unsigned DEB_CYC     = DEB_US * CLK_HZ / 1_000_000;
  localparam longint unsigned FLASH_MS    = 250;
  localparam longint unsigned FLASH_CYC   = FLASH_MS * CLK_HZ / 1000;
  localparam longint unsigned LOCK_S      = 180;
  localparam longint unsigned LOCK_CYC    = LOCK_S * CLK_HZ;
  localparam longint unsigned ONMAX_MS    = 1000;
  localparam longint unsigned ON_WEIGHT   = 66;
  localparam longint unsigned ON_LIMIT    = ON_WEIGHT * ONMAX_MS * CLK_HZ / 1000;
  localparam longint unsigned PREWARN_PCT = 80;
  localparam longint unsigned PCT_FULL    = 100;

  // Widths
  localparam int CNT_W  = 32;
  localparam int LOCK_W = 36;
  localparam int INT_W  = 40;
  localparam int WB_AW  = 8;
  localparam int WB_DW  = 32;
  localparam int WB_SW  = 4;

  // Register map
  localparam logic [WB_AW-1:0] ADR_CTRL = 8'h00;
  localparam logic [WB_AW-1:0] ADR_STAT = 8'h04;
  localparam logic [WB_AW-1:0] ADR_ONT  = 8'h08;
  localparam int               ONT_SH   = 8;

  // Control bits
  localparam int         CTRL_W    = 2;
  localparam int         CTRL_INH  = 0;
  localparam int         CTRL_CHOP = 1;
  localparam logic [1:0] CTRL_RST  = 2'h2;

  // Status bits
  localparam int STAT_OC   = 0;
  localparam int STAT_OT   = 1;
  localparam int STAT_OVL  = 2;
  localparam int STAT_LOCK = 3;
  localparam int STAT_WARN = 4;
  localparam int STAT_RES  = 5;
  localparam int STAT_INH  = 6;
  localparam int STAT_MAN  = 7;

  typedef enum logic [1:0] {
    BU_ST_READY   = 2'b00,
    BU_ST_INHIBIT = 2'b01,
    BU_ST_FAULT   = 2'b10
  } bu_state_t;
endpackage : bu_pkg

// File: sim/bu_term_model.sv
`timescale 1ns/1ps
module bu_term_model (
  input  wire logic clk_i,
  input  wire logic inh_cmd_i,
  input  wire logic man_cmd_i,
  output logic      inh_o,
  output logic      man_o
);
  logic [1:0] inh_b = 2'h0;
  logic [1:0] man_b = 2'h0;
  logic       inh_q = 1'b1;
  logic       man_q = 1'b0;

  // Switch contacts chatter for three cycles after each change
  always @(posedge clk_i) begin
    inh_q <= inh_cmd_i;
    man_q <= man_cmd_i;
    inh_b <= (inh_cmd_i != inh_q) ? 2'h3 : inh_b - {1'b0, inh_b != 2'h0};
    man_b <= (man_cmd_i != man_q) ? 2'h3 : man_b - {1'b0, man_b != 2'h0};
  end

  assign inh_o = inh_b[0] ? ~inh_cmd_i : inh_cmd_i;
  assign man_o = man_b[0] ? ~man_cmd_i : man_cmd_i;
endmodule : bu_term_model

// File: sim/test_bu_brake_ctrl.sv
`timescale 1ns/1ps
module test_bu_brake_ctrl;
  import bu_pkg::*;
  logic             clk_i   = 1'b0;
  logic             rst_n_i = 1'b0;
  logic             cyc     = 1'b0;
  logic             stb     = 1'b0;
  logic             we      = 1'b0;
  logic [WB_AW-1:0] adr     = '0;
  logic [WB_DW-1:0] dat     = '0;
  logic [WB_SW-1:0] sel     = '0;
  logic [WB_DW-1:0] rdat;
  logic             ack;
  logic             inh_cmd = 1'b1;
  logic             man_cmd = 1'b0;
  logic             dc_hi   = 1'b0;
  logic             oc      = 1'b0;
  logic             ot      = 1'b0;
  logic             inh_raw, man_raw, res, warn_n, rdy, grn, red, dled;
  int               num_errors  = 0;
  int               checks_done = 0;

  always #5 clk_i = ~clk_i;

  bu_term_model u_term (.clk_i(clk_i), .inh_cmd_i(inh_cmd), .man_cmd_i(man_cmd), .inh_o(inh_raw), .man_o(man_raw));

  bu_brake_ctrl #(.DEB_CYC(32'h4), .FLASH_CYC(32'h8), .LOCK_CYC(36'hc8), .ON_LIMIT(40'h7d0)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .inhibit_ack_input_i(inh_raw),
    .manual_discharge_input_i(man_raw), .discharge_indicator_high_i(dc_hi), .overcurrent_i(oc),
    .heatsink_overtemp_i(ot), .resistor_switch_o(res), .overload_prewarn_output_o(warn_n),
    .ready_fault_output_o(rdy), .ready_led_green_o(grn), .ready_led_red_o(red),
    .discharge_indicator_o(dled));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [WB_AW-1:0] a, input logic [WB_DW-1:0] d,
                     output logic [WB_DW-1:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : bus

  task automatic settle;
    repeat (20) @(posedge clk_i);
  endtask : settle

  task automatic ack_toggle;
    inh_cmd <= 1'b1;
    settle();
    inh_cmd <= 1'b0;
    settle();
  endtask : ack_toggle

  task automatic test_end(input string name);
    $display("test %s finished", name);
  endtask : test_end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    test_done();
  end

  initial begin
    logic [31:0] v;
    int          n, hi, lo;
    logic        seen_warn;
    repeat (20) @(posedge clk_i);
    check({res, warn_n, rdy, grn, red, dled}, 32'h1a);
    rst_n_i <= 1'b1;
    bus(1'b0, ADR_CTRL, 32'h0, v);
    check(v, 32'(CTRL_RST));
    bus(1'b1, 8'h0c, 32'hffff_ffff, v);
    bus(1'b0, 8'h0c, 32'h0, v);
    check(v, 32'h0);
    test_end("registers");

    inh_cmd <= 1'b0;
    settle();
    check({rdy, grn, red}, 32'h6);
    bus(1'b0, ADR_STAT, 32'h0, v);
    check(v[STAT_INH], 32'h0);
    test_end("enable");

    dc_hi <= 1'b1;
    repeat (4) @(posedge clk_i);
    check(res, 32'h1);
    bus(1'b1, ADR_CTRL, 32'h0, v);
    repeat (3) @(posedge clk_i);
    check(res, 32'h0);
    bus(1'b1, ADR_CTRL, 32'h3, v);
    repeat (3) @(posedge clk_i);
    check(res, 32'h0);
    bus(1'b1, ADR_CTRL, 32'h2, v);
    repeat (3) @(posedge clk_i);
    check(res, 32'h1);
    dc_hi <= 1'b0;
    repeat (1000) @(posedge clk_i);
    bus(1'b0, ADR_ONT, 32'h0, v);
    check(v, 32'h0);
    test_end("chopper");

    for (int i = 0; i < 2; i++) begin
      if (i == 0) oc <= 1'b1;
      else ot <= 1'b1;
      @(posedge clk_i);
      oc <= 1'b0;
      ot <= 1'b0;
      repeat (4) @(posedge clk_i);
      check({res, rdy, grn, red}, 32'h1);
      bus(1'b0, ADR_STAT, 32'h0, v);
      check(v[STAT_OC+i], 32'h1);
      ack_toggle();
      check({rdy, grn, red}, 32'h6);
      bus(1'b0, ADR_STAT, 32'h0, v);
      check(v[1:0], 32'h0);
    end
    test_end("faults");

    inh_cmd <= 1'b1;
    man_cmd <= 1'b1;
    settle();
    check({res, red, dled}, 32'h2);
    bus(1'b0, ADR_STAT, 32'h0, v);
    check(v[STAT_MAN], 32'h1);
    inh_cmd <= 1'b0;
    n = 0;
    while (res !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    check(res, 32'h1);
    n = 0;
    hi = 0;
    lo = 0;
    seen_warn = 1'b0;
    while (rdy !== 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
      if (dled === 1'b1) hi++;
      else lo++;
      if (warn_n === 1'b0 && rdy === 1'b1) seen_warn = 1'b1;
    end
    check(hi > 0 && lo > 0, 32'h1);
    check(seen_warn, 32'h1);
    check(rdy, 32'h0);
    repeat (2) @(posedge clk_i);
    check({res, red, warn_n}, 32'h2);
    bus(1'b0, ADR_STAT, 32'h0, v);
    check({v[STAT_LOCK], v[STAT_OVL]}, 32'h3);
    man_cmd <= 1'b0;
    ack_toggle();
    check(rdy, 32'h0);
    repeat (250) @(posedge clk_i);
    bus(1'b0, ADR_STAT, 32'h0, v);
    check(v[STAT_LOCK], 32'h0);
    ack_toggle();
    check({rdy, grn, dled}, 32'h6);
    test_end("overload");
    test_done();
  end
endmodule : test_bu_brake_ctrl
